// file: design/cod_decoder.sv
// Opcode decoder with its APB register file and bus lock output.
module cod_decoder
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             bus_lock_n
);
	import cod_pkg::*;

	// ****************************************
	// Opcode table
	// ****************************************
	function automatic cod_dec_s decode_op
	(
		input logic [7:0] b0,
		input logic [7:0] b1
	);
		cod_dec_s   d;
		logic [2:0] immw;
		logic [2:0] mid;
		immw = b0[0] ? 3'h2 : 3'h1;
		mid = b1[5:3];
		d = '0;
		d.op = OP_UNK;
		d.wide = b0[0];
		casez (b0)
		8'b1111011?:
		begin
			d.modrm = 1'b1;
			case (mid)
			3'h0:
			begin
				d.op = OP_FLAND;
				d.imm_n = immw;
			end
			3'h2: d.op = OP_INV;
			3'h3: d.op = OP_NEGT;
			3'h4: d.op = OP_UPROD;
			3'h5: d.op = OP_SPROD;
			3'h6: d.op = OP_UQUOT;
			3'h7: d.op = OP_SQUOT;
			default: d.op = OP_UNK;
			endcase
		end
		8'b110100??:
		begin
			d.modrm = 1'b1;
			d.cnt_src = b0[1];
			case (mid)
			3'h0: d.op = OP_LROT;
			3'h1: d.op = OP_RROT;
			3'h2: d.op = OP_LROTC;
			3'h3: d.op = OP_RROTC;
			3'h4: d.op = OP_LSH;
			3'h5: d.op = OP_LRSH;
			3'h7: d.op = OP_ARSH;
			default: d.op = OP_UNK;
			endcase
		end
		8'b100000??:
		begin
			d.modrm = 1'b1;
			d.sext = b0[1];
			d.imm_n = (b0[1:0] == 2'h1) ? 3'h2 : 3'h1;
			case (mid)
			3'h4: d.op = OP_AND;
			3'h1: d.op = OP_OR;
			3'h6: d.op = OP_XOR;
			default: d.op = OP_UNK;
			endcase
		end
		8'b001000??:
		begin
			d.op = OP_AND;
			d.modrm = 1'b1;
			d.dir = b0[1];
		end
		8'b000010??:
		begin
			d.op = OP_OR;
			d.modrm = 1'b1;
			d.dir = b0[1];
		end
		8'b001100??:
		begin
			d.op = OP_XOR;
			d.modrm = 1'b1;
			d.dir = b0[1];
		end
		8'b0010010?:
		begin
			d.op = OP_AND;
			d.imm_n = immw;
		end
		8'b0000110?:
		begin
			d.op = OP_OR;
			d.imm_n = immw;
		end
		8'b0011010?:
		begin
			d.op = OP_XOR;
			d.imm_n = immw;
		end
		8'b1000010?:
		begin
			d.op = OP_FLAND;
			d.modrm = 1'b1;
		end
		8'b1010100?:
		begin
			d.op = OP_FLAND;
			d.imm_n = immw;
		end
		8'hD4, 8'hD5:
		begin
			d.op = (b1 != ADJ_BYTE) ? OP_UNK :
				(b0[0] ? OP_BCDQ : OP_BCDP);
			d.imm_n = 3'h1;
		end
		8'h98: d.op = OP_B2W;
		8'h99: d.op = OP_W2D;
		8'b1010010?: d.op = OP_SCOPY;
		8'b1010011?: d.op = OP_SCMP;
		8'b1010111?: d.op = OP_SSRCH;
		8'b1010110?: d.op = OP_SFETCH;
		8'b1010101?: d.op = OP_SDEP;
		8'b1111001?:
		begin
			d.op = OP_SITER;
			d.prefix = 1'b1;
		end
		8'hE9, 8'hE8:
		begin
			d.op = b0[0] ? OP_JNEAR : OP_CNEAR;
			d.imm_n = 3'h2;
		end
		8'hEB:
		begin
			d.op = OP_JSHORT;
			d.imm_n = 3'h1;
			d.sext = 1'b1;
		end
		8'hEA, 8'h9A:
		begin
			d.op = b0[7:4] == 4'hE ? OP_JFAR : OP_CFAR;
			d.imm_n = 3'h4;
		end
		8'hFF:
		begin
			d.modrm = 1'b1;
			case (mid)
			3'h2: d.op = OP_CIND;
			3'h3: d.op = OP_CINDF;
			3'h4: d.op = OP_JIND;
			3'h5: d.op = OP_JINDF;
			default: d.op = OP_UNK;
			endcase
		end
		8'hC3: d.op = OP_RTN;
		8'hCB: d.op = OP_RTNF;
		8'hC2, 8'hCA:
		begin
			d.op = b0[3] ? OP_RTNFA : OP_RTNA;
			d.imm_n = 3'h2;
		end
		8'b0111????, 8'b111000??:
		begin
			d.imm_n = 3'h1;
			d.sext = 1'b1;
			case (b0[7:4] == 4'h7 ? 2'h0 : {1'b1, b0[1] ^ b0[0]})
			2'h0: d.op = OP_JCOND;
			default: d.op = b0[1] ? (b0[0] ? OP_JCTRZ : OP_LOOP)
				: (b0[0] ? OP_LOOPZ : OP_LOOPNZ);
			endcase
		end
		8'hCD:
		begin
			d.op = OP_SWINT;
			d.imm_n = 3'h1;
		end
		8'hCC: d.op = OP_BRKPT;
		8'hCE: d.op = OP_INTOVF;
		8'hCF: d.op = OP_INTRTN;
		8'hF8: d.op = OP_CLRC;
		8'hF5: d.op = OP_CMPC;
		8'hF9: d.op = OP_SETC;
		8'hFC: d.op = OP_CLRD;
		8'hFD: d.op = OP_SETD;
		8'hFA: d.op = OP_CLRI;
		8'hFB: d.op = OP_SETI;
		8'hF4: d.op = OP_HALT;
		8'h9B: d.op = OP_WAIT;
		8'b11011???:
		begin
			d.op = OP_ESC;
			d.modrm = 1'b1;
		end
		8'hF0:
		begin
			d.op = OP_BLOCK;
			d.prefix = 1'b1;
		end
		8'b001??110:
		begin
			d.op = OP_SEGOV;
			d.prefix = 1'b1;
		end
		default: d.op = OP_UNK;
		endcase
		return d;
	endfunction

	// ****************************************
	// Storage
	// ****************************************
	logic     [31:0] code_lo;
	logic     [15:0] code_hi;
	logic     [15:0] base_word;
	logic     [15:0] frame_base_pointer;
	logic     [15:0] src_index;
	logic     [15:0] destination_index;
	logic     [15:0] word_counter;
	logic     [15:0] flags;
	cod_res_s        res0;
	logic     [31:0] res1;
	logic     [31:0] res2;
	logic     [31:0] res3;
	logic            iter_pend;
	logic            iter_z;
	logic            seg_pend;
	logic     [1:0]  seg_code;
	logic            lock_armed;

	// ****************************************
	// Field extraction and operand forming
	// ****************************************
	wire logic [47:0] code = {code_hi, code_lo};
	wire logic [7:0]  b0 = code[7:0];
	wire logic [7:0]  b1 = code[15:8];
	wire logic [7:0]  b2 = code[23:16];
	wire logic [7:0]  b3 = code[31:24];
	wire cod_dec_s    dec = decode_op(b0, b1);
	wire logic [1:0]  mode = b1[7:6];
	wire logic [2:0]  rm = b1[2:0];
	wire logic        unknown = (dec.op == OP_UNK);
	wire logic        mem_opnd = dec.modrm && (mode != MODE_REG);
	wire logic        direct = mem_opnd && (mode == MODE_NONE)
		&& (rm == RM_DIRECT);
	wire logic [1:0]  disp_n = !mem_opnd ? 2'h0 :
		(direct || mode == MODE_D16) ? 2'h2 :
		(mode == MODE_D8) ? 2'h1 : 2'h0;
	wire logic [15:0] disp16 = {b3, b2};
	wire logic [15:0] disp_val = (disp_n == 2'h1) ? {{8{b2[7]}}, b2} :
		(disp_n == 2'h2) ? disp16 : 16'h0;
	wire logic [2:0]  imm_at = 3'h1 + {2'h0, dec.modrm}
		+ {1'b0, disp_n};
	wire logic [47:0] imm_src = code >> {imm_at, 3'h0};
	wire logic [7:0]  imm8 = imm_src[7:0];
	wire logic [31:0] imm_val = (dec.imm_n == 3'h4) ? imm_src[31:0] :
		(dec.imm_n == 3'h2) ? {16'h0, imm_src[15:0]} :
		(dec.imm_n == 3'h1 && dec.sext) ? {{24{imm8[7]}}, imm8} :
		(dec.imm_n == 3'h1) ? {24'h0, imm8} : 32'h0;
	wire logic [3:0]  len = {1'b0, imm_at} + {1'b0, dec.imm_n};
	wire logic [15:0] addr_base = (rm[2:1] == 2'h3) ?
		(rm[0] ? base_word : frame_base_pointer) :
		rm[2] ? 16'h0 :
		(rm[1] ? frame_base_pointer : base_word);
	wire logic [15:0] addr_index = (rm[2:1] == 2'h3) ? 16'h0 :
		(rm[0] ? destination_index : src_index);
	wire logic [15:0] effective_address = !mem_opnd ? 16'h0 :
		direct ? disp16 : addr_base + addr_index + disp_val;
	wire logic [7:0]  shift_cnt = dec.cnt_src ? word_counter[7:0]
		: SHIFT_ONE;
	wire logic [7:0]  int_type = (b0 == 8'hCC) ? BREAK_TYPE : b1;
	wire logic        cmp_str = (dec.op == OP_SCMP)
		|| (dec.op == OP_SSRCH);
	wire logic        iter_cont = iter_pend && (!cmp_str
		|| (flags[ZERO_FLAG] == iter_z));
	wire logic        reg_hi = !dec.wide && b1[5];

	wire cod_res_s next_res0 = '{
		pad: 1'b0,
		seg: seg_code,
		seg_v: seg_pend,
		lock: !bus_lock_n,
		iter_cont: iter_cont,
		iter_z: iter_z,
		iter_act: iter_pend,
		sext: dec.sext,
		direct: direct,
		mem: mem_opnd,
		unknown: unknown,
		len: len,
		mode: mode,
		rm: rm,
		rsel: b1[5:3],
		dir: dec.dir,
		wide: dec.wide,
		op: dec.op
	};
	wire logic [31:0] next_res1 = {disp_val, effective_address};
	wire logic [31:0] next_res3 = {8'h0, int_type, reg_hi,
		dec.imm_n, b0[3:0], shift_cnt};

	// ****************************************
	// APB decode
	// ****************************************
	wire logic        setup = psel && !penable;
	wire logic        addr_ok = (paddr[1:0] == 2'h0)
		&& (paddr <= A_RES3);
	wire logic        wr_en = psel && penable && pready && pwrite
		&& addr_ok;
	wire logic        ctrl_wr = wr_en && (paddr == A_CTRL);
	wire logic        decode_go = ctrl_wr && pwdata[CTRL_DECODE];
	wire logic        retire_go = ctrl_wr && pwdata[CTRL_RETIRE];
	wire logic        lock_set = decode_go && (dec.op == OP_BLOCK);
	wire logic [31:0] rd_data =
		(paddr == A_CODE_LO) ? code_lo :
		(paddr == A_CODE_HI) ? {16'h0, code_hi} :
		(paddr == A_BASE) ? {frame_base_pointer, base_word} :
		(paddr == A_INDEX) ? {destination_index, src_index} :
		(paddr == A_FLCX) ? {word_counter, flags} :
		(paddr == A_RES0) ? res0 :
		(paddr == A_RES1) ? res1 :
		(paddr == A_RES2) ? res2 :
		(paddr == A_RES3) ? res3 : 32'h0;
	wire logic        next_lock_n = lock_set ? 1'b0 :
		(retire_go && lock_armed) ? 1'b1 : bus_lock_n;
	wire logic        next_armed = lock_set ? 1'b0 :
		(decode_go && !dec.prefix && !bus_lock_n) ? 1'b1 :
		retire_go ? 1'b0 : lock_armed;

	// ****************************************
	// Bus answer
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= RST_WORD;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && !addr_ok;
			prdata <= setup ? rd_data : RST_WORD;
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			code_lo <= RST_WORD;
			code_hi <= RST_WORD[15:0];
			base_word <= RST_WORD[15:0];
			frame_base_pointer <= RST_WORD[15:0];
			src_index <= RST_WORD[15:0];
			destination_index <= RST_WORD[15:0];
			word_counter <= RST_WORD[15:0];
			flags <= RST_WORD[15:0];
		end
		else if (wr_en)
		begin
			unique case (paddr)
			A_CODE_LO: code_lo <= pwdata;
			A_CODE_HI: code_hi <= pwdata[15:0];
			A_BASE:
			begin
				base_word <= pwdata[15:0];
				frame_base_pointer <= pwdata[31:16];
			end
			A_INDEX:
			begin
				src_index <= pwdata[15:0];
				destination_index <= pwdata[31:16];
			end
			A_FLCX:
			begin
				flags <= pwdata[15:0] & FLAG_MASK;
				word_counter <= pwdata[31:16];
			end
			default: ;
			endcase
		end
	end

	// ****************************************
	// Decode results and prefix state
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			res0 <= RST_WORD;
			res1 <= RST_WORD;
			res2 <= RST_WORD;
			res3 <= RST_WORD;
			iter_pend <= 1'b0;
			iter_z <= 1'b0;
			seg_pend <= 1'b0;
			seg_code <= RST_WORD[1:0];
		end
		else if (decode_go)
		begin
			res0 <= next_res0;
			res1 <= next_res1;
			res2 <= imm_val;
			res3 <= next_res3;
			iter_pend <= (dec.op == OP_SITER) || (dec.prefix && iter_pend);
			if (dec.op == OP_SITER)
				iter_z <= b0[0];
			seg_pend <= (dec.op == OP_SEGOV) || (dec.prefix && seg_pend);
			if (dec.op == OP_SEGOV)
				seg_code <= b0[4:3];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bus_lock_n <= RST_LOCK_N;
			lock_armed <= 1'b0;
		end
		else
		begin
			bus_lock_n <= next_lock_n;
			lock_armed <= next_armed;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	disp_byte_a: assert property (
		decode_go && dec.modrm && mode == MODE_D8 && !unknown
		|=> res1[31:16] == {{8{$past(b2[7])}}, $past(b2)})
		else $error("short displacement not sign extended");
	addr_sum_a: assert property (
		decode_go && dec.modrm && mode == MODE_NONE && rm == 3'h0
		|=> res1[15:0] == 16'($past(base_word) + $past(src_index)))
		else $error("base plus index address wrong");
	direct_addr_a: assert property (
		decode_go && direct |=> res1[15:0] == {$past(b3), $past(b2)})
		else $error("direct address wrong");
	imm_sext_a: assert property (
		decode_go && b0 == 8'h83 && mode == MODE_REG
		|=> res2 == {{24{$past(b2[7])}}, $past(b2)} && res0.len == 4'h3)
		else $error("sign extended immediate wrong");
	shift_count_a: assert property (
		decode_go && b0 == 8'hD2 |=> res3[7:0] == $past(word_counter[7:0]))
		else $error("shift count not from counter");
	flag_layout_a: assert property (
		(flags & ~FLAG_MASK) == 16'h0)
		else $error("unused status bit set");
	lock_hold_a: assert property (
		lock_set || (!bus_lock_n && !(retire_go && lock_armed))
		|=> !bus_lock_n)
		else $error("bus lock not held");
	lock_release_a: assert property (
		$rose(bus_lock_n) |-> $past(retire_go) && $past(lock_armed))
		else $error("bus lock released early");
	unknown_op_a: assert property (
		decode_go && b0 == 8'h0F |=> res0.unknown && res0.op == OP_UNK)
		else $error("unlisted opcode not flagged");
	apb_answer_a: assert property (
		setup |=> pready ##1 !pready)
		else $error("apb answer timing wrong");

	iter_cmp_c: cover property (decode_go && iter_pend && cmp_str);
	lock_c: cover property (lock_set ##[1:20] retire_go && lock_armed);
	direct_c: cover property (decode_go && direct);
	far_jump_c: cover property (decode_go && dec.op == OP_JFAR);
endmodule

// file: dv/test_cod_decoder.sv
// Self-checking testbench for the opcode decoder over its register bus.
module test_cod_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	import cod_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	typedef struct packed {
		logic [47:0] code;
		cod_op_e     op;
		logic [3:0]  len;
	} cod_row_s;

	localparam int N_ROWS = 74;
	localparam logic [15:0] ADDR_TAB [8] = '{16'h1030, 16'h1400, 16'h2030,
		16'h2400, 16'h0030, 16'h0400, 16'h2000, 16'h1000};

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        bus_lock_n;
	logic [31:0] rd;
	logic        er;
	cod_res_s    r0;
	logic [31:0] r1;
	logic [31:0] r2;
	logic [31:0] r3;
	logic [31:0] keep;
	int          n_errors;
	int          n_checks;

	cod_row_s rows [N_ROWS] = '{
		'{48'hE0F7,OP_UPROD,4'h2}, '{48'hE8F7,OP_SPROD,4'h2},
		'{48'hF0F6,OP_UQUOT,4'h2}, '{48'hF8F7,OP_SQUOT,4'h2},
		'{48'hD0F7,OP_INV,4'h2}, '{48'hD8F6,OP_NEGT,4'h2},
		'{48'h55C0F6,OP_FLAND,4'h3}, '{48'hC8F7,OP_UNK,4'h2},
		'{48'h0AD4,OP_BCDP,4'h2}, '{48'h0AD5,OP_BCDQ,4'h2},
		'{48'h98,OP_B2W,4'h1}, '{48'h99,OP_W2D,4'h1},
		'{48'hC0D1,OP_LROT,4'h2}, '{48'hC8D1,OP_RROT,4'h2},
		'{48'hD0D1,OP_LROTC,4'h2}, '{48'hD8D1,OP_RROTC,4'h2},
		'{48'hE0D1,OP_LSH,4'h2}, '{48'hE8D1,OP_LRSH,4'h2},
		'{48'hF8D1,OP_ARSH,4'h2}, '{48'hF0D1,OP_UNK,4'h2},
		'{48'hC020,OP_AND,4'h2}, '{48'hC008,OP_OR,4'h2},
		'{48'hC030,OP_XOR,4'h2}, '{48'h5634E081,OP_AND,4'h4},
		'{48'h12C880,OP_OR,4'h3}, '{48'h12F083,OP_XOR,4'h3},
		'{48'h1224,OP_AND,4'h2}, '{48'h12340D,OP_OR,4'h3},
		'{48'h1234,OP_XOR,4'h2}, '{48'hC081,OP_UNK,4'h2},
		'{48'hC085,OP_FLAND,4'h2}, '{48'h1234A9,OP_FLAND,4'h3},
		'{48'h12A8,OP_FLAND,4'h2}, '{48'h0BD4,OP_UNK,4'h2},
		'{48'hA4,OP_SCOPY,4'h1}, '{48'hA7,OP_SCMP,4'h1},
		'{48'hAF,OP_SSRCH,4'h1}, '{48'hAC,OP_SFETCH,4'h1},
		'{48'hAB,OP_SDEP,4'h1}, '{48'hF3,OP_SITER,4'h1},
		'{48'h1234E9,OP_JNEAR,4'h3}, '{48'h12EB,OP_JSHORT,4'h2},
		'{48'hF0001234EA,OP_JFAR,4'h5}, '{48'hE0FF,OP_JIND,4'h2},
		'{48'hE8FF,OP_JINDF,4'h2}, '{48'hD0FF,OP_CIND,4'h2},
		'{48'hD8FF,OP_CINDF,4'h2}, '{48'h1234E8,OP_CNEAR,4'h3},
		'{48'hF00012349A,OP_CFAR,4'h5}, '{48'hC0FF,OP_UNK,4'h2},
		'{48'hC3,OP_RTN,4'h1}, '{48'h0008C2,OP_RTNA,4'h3},
		'{48'hCB,OP_RTNF,4'h1}, '{48'h0008CA,OP_RTNFA,4'h3},
		'{48'h10E2,OP_LOOP,4'h2}, '{48'h10E1,OP_LOOPZ,4'h2},
		'{48'h10E0,OP_LOOPNZ,4'h2}, '{48'h10E3,OP_JCTRZ,4'h2},
		'{48'h21CD,OP_SWINT,4'h2}, '{48'hCC,OP_BRKPT,4'h1},
		'{48'hCE,OP_INTOVF,4'h1}, '{48'hCF,OP_INTRTN,4'h1},
		'{48'hF8,OP_CLRC,4'h1}, '{48'hF5,OP_CMPC,4'h1},
		'{48'hF9,OP_SETC,4'h1}, '{48'hFC,OP_CLRD,4'h1},
		'{48'hFD,OP_SETD,4'h1}, '{48'hFA,OP_CLRI,4'h1},
		'{48'hFB,OP_SETI,4'h1}, '{48'hF4,OP_HALT,4'h1},
		'{48'h9B,OP_WAIT,4'h1}, '{48'hC0D8,OP_ESC,4'h2},
		'{48'h26,OP_SEGOV,4'h1}, '{48'h3E,OP_SEGOV,4'h1}
	};

	cod_decoder i_cod_decoder
	(
		.pclk       (pclk),
		.presetn    (presetn),
		.psel       (psel),
		.penable    (penable),
		.pwrite     (pwrite),
		.paddr      (paddr),
		.pwdata     (pwdata),
		.prdata     (prdata),
		.pready     (pready),
		.pslverr    (pslverr),
		.bus_lock_n (bus_lock_n)
	);

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1);
		chk("access cycles", 32'h1, 32'(n));
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic dec(input logic [47:0] c);
		apb(1'b1, A_CODE_LO, c[31:0]);
		apb(1'b1, A_CODE_HI, {16'h0000, c[47:32]});
		apb(1'b1, A_CTRL, 32'h00000001);
		apb(1'b0, A_RES0, 32'h00000000);
		r0 = cod_res_s'(rd);
		apb(1'b0, A_RES1, 32'h00000000);
		r1 = rd;
		apb(1'b0, A_RES2, 32'h00000000);
		r2 = rd;
		apb(1'b0, A_RES3, 32'h00000000);
		r3 = rd;
	endtask

	task automatic close_out();
		$display("checks %0d, mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ****************************************
	// Clock, reset and watchdog
	// ****************************************
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	initial
	begin
		repeat (30000) @(posedge pclk);
		n_errors++;
		$display("test watchdog expired");
		close_out();
	end

	// ****************************************
	// Stimulus
	// ****************************************
	initial
	begin
		n_errors = 0;
		n_checks = 0;
		presetn <= 1'b0;
		psel    <= 1'b0;
		penable <= 1'b0;
		pwrite  <= 1'b0;
		paddr   <= 8'h00;
		pwdata  <= 32'h00000000;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		chk("lock_n", 32'h1, 32'(bus_lock_n));
		for (int a = 0; a <= 36; a += 4)
		begin
			apb(1'b0, 8'(a), 32'h00000000);
			chk("reset value", 32'h00000000, rd);
		end
		$display("test reset done");
		for (int i = 0; i < N_ROWS; i++)
		begin
			dec(rows[i].code);
			chk("op", 32'(rows[i].op), 32'(r0.op));
			chk("unknown", 32'(rows[i].op == OP_UNK), 32'(r0.unknown));
			if (rows[i].op != OP_UNK)
				chk("len", 32'(rows[i].len), 32'(r0.len));
		end
		$display("test opcode table done");
		apb(1'b1, A_BASE, 32'h20001000);
		apb(1'b1, A_INDEX, 32'h04000030);
		for (int m = 0; m < 8; m++)
		begin
			dec({24'h000000, 8'h80, 2'b01, 3'b000, 3'(m), 8'h20});
			chk("address", {16'hFF80, 16'(ADDR_TAB[m] + 16'hFF80)}, r1);
			chk("len", 32'h3, 32'(r0.len));
		end
		dec(48'h000000000020);
		chk("address mode 0", 32'h1030, 32'(r1[15:0]));
		dec(48'h000012340620);
		chk("direct address", 32'h1234, 32'(r1[15:0]));
		chk("direct", 32'h1, 32'(r0.direct));
		dec(48'h000012348720);
		chk("address d16", 32'h2234, 32'(r1[15:0]));
		dec(48'h56781234A781);
		chk("imm", 32'h5678, 32'(r2[15:0]));
		chk("disp", 32'h1234, 32'(r1[31:16]));
		chk("len", 32'h6, 32'(r0.len));
		dec(48'h0000FEE083);
		chk("sext imm", 32'hFFFE, 32'(r2[15:0]));
		chk("sext", 32'h1, 32'(r0.sext));
		dec(48'hD822);
		chk("mem", 32'h0, 32'(r0.mem));
		chk("fields", 32'h30E, 32'({r0.mode, r0.rm, r0.rsel, r0.dir, r0.wide}));
		dec(48'hD821);
		chk("wide dir", 32'h1, 32'({r0.dir, r0.wide}));
		$display("test addressing done");
		apb(1'b1, A_FLCX, 32'h0105FFFF);
		apb(1'b0, A_FLCX, 32'h00000000);
		chk("flags", 32'h01050FD5, rd);
		dec(48'hE0D2);
		chk("count", 32'h05, 32'(r3[7:0]));
		dec(48'hE0D0);
		chk("count", 32'h01, 32'(r3[7:0]));
		dec(48'hF3);
		dec(48'hA6);
		chk("repeat", 32'h7, 32'({r0.iter_cont, r0.iter_z, r0.iter_act}));
		dec(48'hF2);
		dec(48'hA6);
		chk("repeat", 32'h1, 32'({r0.iter_cont, r0.iter_z, r0.iter_act}));
		for (int s = 0; s < 4; s++)
		begin
			dec({40'h0000000000, 3'b001, 2'(s), 3'b110});
			dec(48'hA4);
			chk("segment", 32'(2 * s + 1), 32'({r0.seg, r0.seg_v}));
		end
		for (int c = 0; c < 16; c++)
		begin
			dec({32'h00000000, 8'h10, 4'h7, 4'(c)});
			chk("cond", 32'(c), 32'(r3[11:8]));
			chk("op", 32'(OP_JCOND), 32'(r0.op));
		end
		dec(48'hCC);
		chk("type", 32'h03, 32'(r3[23:16]));
		dec(48'h21CD);
		chk("type", 32'h21, 32'(r3[23:16]));
		dec(48'hF0001234EA);
		chk("far", 32'hF0001234, r2);
		dec(48'h0008C2);
		chk("stack adj", 32'h0008, 32'(r2[15:0]));
		dec(48'h0F);
		chk("unknown", 32'h1, 32'(r0.unknown));
		$display("test operands done");
		dec(48'hF0);
		chk("lock_n", 32'h0, 32'(bus_lock_n));
		apb(1'b1, A_CTRL, 32'h00000002);
		chk("lock_n", 32'h0, 32'(bus_lock_n));
		dec(48'hA4);
		chk("lock_n", 32'h0, 32'(bus_lock_n));
		apb(1'b1, A_CTRL, 32'h00000002);
		apb(1'b0, A_CTRL, 32'h00000000);
		chk("lock_n", 32'h1, 32'(bus_lock_n));
		chk("ctrl read", 32'h0, rd);
		$display("test lock done");
		keep = r0;
		apb(1'b1, A_RES0, 32'hFFFFFFFF);
		chk("ro err", 32'h0, 32'(er));
		apb(1'b0, A_RES0, 32'h00000000);
		chk("ro keep", keep, rd);
		apb(1'b0, 8'h28, 32'h00000000);
		chk("unmapped", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, 8'h02, 32'h00000001);
		chk("unaligned", 32'h1, {31'h0, er});
		$display("test bus refusals done");
		close_out();
	end
endmodule

// file: shared/cod_pkg.sv
// Constants and types shared by the opcode decoder.
package cod_pkg;

	// ****************************************
	// Register map and control bits
	// ****************************************
	localparam logic [7:0] A_CODE_LO = 8'h00;
	localparam logic [7:0] A_CODE_HI = 8'h04;
	localparam logic [7:0] A_BASE    = 8'h08;
	localparam logic [7:0] A_INDEX   = 8'h0C;
	localparam logic [7:0] A_FLCX    = 8'h10;
	localparam logic [7:0] A_CTRL    = 8'h14;
	localparam logic [7:0] A_RES0    = 8'h18;
	localparam logic [7:0] A_RES1    = 8'h1C;
	localparam logic [7:0] A_RES2    = 8'h20;
	localparam logic [7:0] A_RES3    = 8'h24;
	localparam int CTRL_DECODE = 0;
	localparam int CTRL_RETIRE = 1;

	// ****************************************
	// Status word layout
	// ****************************************
	localparam int OVERFLOW_FLAG    = 11;
	localparam int DIRECTION_FLAG   = 10;
	localparam int INT_ENABLE_FLAG  = 9;
	localparam int SINGLE_STEP_FLAG = 8;
	localparam int SIGN_FLAG        = 7;
	localparam int ZERO_FLAG        = 6;
	localparam int AUX_CARRY_FLAG   = 4;
	localparam int PARITY_FLAG      = 2;
	localparam int CARRY_FLAG       = 0;
	localparam logic [15:0] FLAG_MASK = 16'h0FD5;

	// ****************************************
	// Encoding constants and reset values
	// ****************************************
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_D8   = 2'h1;
	localparam logic [1:0] MODE_D16  = 2'h2;
	localparam logic [1:0] MODE_REG  = 2'h3;
	localparam logic [2:0] RM_DIRECT = 3'h6;
	localparam logic [7:0] ADJ_BYTE   = 8'h0A;
	localparam logic [7:0] BREAK_TYPE = 8'h03;
	localparam logic [7:0] SHIFT_ONE  = 8'h01;
	localparam logic [31:0] RST_WORD  = 32'h0;
	localparam logic RST_LOCK_N = 1'b1;

	typedef enum logic [5:0] {
		OP_UNK=6'h00, OP_FLAND=6'h01, OP_INV=6'h02, OP_NEGT=6'h03,
		OP_UPROD=6'h04, OP_SPROD=6'h05, OP_UQUOT=6'h06, OP_SQUOT=6'h07,
		OP_BCDP=6'h08, OP_BCDQ=6'h09, OP_B2W=6'h0A, OP_W2D=6'h0B,
		OP_LROT=6'h0C, OP_RROT=6'h0D, OP_LROTC=6'h0E, OP_RROTC=6'h0F,
		OP_LSH=6'h10, OP_LRSH=6'h11, OP_ARSH=6'h12, OP_AND=6'h13,
		OP_OR=6'h14, OP_XOR=6'h15, OP_SCOPY=6'h16, OP_SCMP=6'h17,
		OP_SSRCH=6'h18, OP_SFETCH=6'h19, OP_SDEP=6'h1A, OP_SITER=6'h1B,
		OP_JNEAR=6'h1C, OP_JSHORT=6'h1D, OP_JFAR=6'h1E, OP_JIND=6'h1F,
		OP_JINDF=6'h20, OP_CNEAR=6'h21, OP_CFAR=6'h22, OP_CIND=6'h23,
		OP_CINDF=6'h24, OP_RTN=6'h25, OP_RTNA=6'h26, OP_RTNF=6'h27,
		OP_RTNFA=6'h28, OP_JCOND=6'h29, OP_LOOP=6'h2A, OP_LOOPZ=6'h2B,
		OP_LOOPNZ=6'h2C, OP_JCTRZ=6'h2D, OP_SWINT=6'h2E, OP_BRKPT=6'h2F,
		OP_INTOVF=6'h30, OP_INTRTN=6'h31, OP_CLRC=6'h32, OP_CMPC=6'h33,
		OP_SETC=6'h34, OP_CLRD=6'h35, OP_SETD=6'h36, OP_CLRI=6'h37,
		OP_SETI=6'h38, OP_HALT=6'h39, OP_WAIT=6'h3A, OP_ESC=6'h3B,
		OP_BLOCK=6'h3C, OP_SEGOV=6'h3D
	} cod_op_e;

	typedef struct packed {
		cod_op_e    op;
		logic       wide;
		logic       dir;
		logic       modrm;
		logic [2:0] imm_n;
		logic       sext;
		logic       cnt_src;
		logic       prefix;
	} cod_dec_s;

	typedef struct packed {
		logic       pad;
		logic [1:0] seg;
		logic       seg_v;
		logic       lock;
		logic       iter_cont;
		logic       iter_z;
		logic       iter_act;
		logic       sext;
		logic       direct;
		logic       mem;
		logic       unknown;
		logic [3:0] len;
		logic [1:0] mode;
		logic [2:0] rm;
		logic [2:0] rsel;
		logic       dir;
		logic       wide;
		cod_op_e    op;
	} cod_res_s;

endpackage
